// file: ola_load_if.sv
/*
 Carrier between the OTP loader and the register file.
 Assumes both ends run on the same clock.
*/
interface ola_load_if;
    logic [5:0] otpAddr;
    logic       otpRd;
    logic [7:0] otpData;
    logic       wrEn;
    logic [4:0] wrIdx;
    logic [7:0] wrData;
    logic       done;

    modport loader (output otpAddr, otpRd, wrEn, wrIdx, wrData, done, input otpData);
    modport regs   (input otpAddr, otpRd, wrEn, wrIdx, wrData, done, output otpData);
endinterface

// file: ola_otp_loader.sv
/*
 Walks the OTP map once after reset and writes each byte to the register file.
 Assumes OTP data is valid in the cycle after a read strobe.
*/
module ola_otp_loader (
    input wire logic  clk,
    input wire logic  rst_b,
    ola_load_if.loader ld
);
    ola_pkg::ola_ld_state_t state_ff;
    logic [4:0]             idx_ff;

    ////////////////////////////////////////////////////////////////////////////////////////
    // walk OTP map
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff   <= ola_pkg::LD_REQ;
            idx_ff     <= 5'h00;
            ld.otpAddr <= 6'h00;
            ld.otpRd   <= 1'b0;
            ld.wrEn    <= 1'b0;
            ld.wrIdx   <= 5'h00;
            ld.wrData  <= 8'h00;
            ld.done    <= 1'b0;
        end else begin
            case (state_ff)
                ola_pkg::LD_REQ: begin
                    ld.wrEn    <= 1'b0;
                    ld.otpAddr <= ola_pkg::OTP_MAP[idx_ff];
                    ld.otpRd   <= 1'b1;
                    state_ff   <= ola_pkg::LD_WAIT;
                end
                ola_pkg::LD_WAIT: begin
                    ld.otpRd <= 1'b0;
                    state_ff <= ola_pkg::LD_CAP;
                end
                ola_pkg::LD_CAP: begin
                    ld.wrEn   <= 1'b1;
                    ld.wrIdx  <= idx_ff;
                    ld.wrData <= ld.otpData;
                    if (idx_ff == 5'(ola_pkg::NUM_LOAD - 1)) begin
                        state_ff <= ola_pkg::LD_DONE;
                    end else begin
                        idx_ff   <= idx_ff + 5'h01;
                        state_ff <= ola_pkg::LD_REQ;
                    end
                end
                default: begin
                    ld.wrEn <= 1'b0;
                    ld.done <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_load_addr_map: assert property (ld.wrEn |-> ld.otpAddr == ola_pkg::OTP_MAP[ld.wrIdx])
        else $error("loaded byte came from the wrong OTP address");
    // The last write is followed by none, so it is left out of the spacing check.
    a_load_spacing: assert property (ld.wrEn && ld.wrIdx != 5'(ola_pkg::NUM_LOAD - 1)
        |=> !ld.wrEn ##1 !ld.wrEn ##1 ld.wrEn)
        else $error("loader writes not three cycles apart");
    c_load_finish: cover property ($rose(ld.done));
endmodule

// file: ola_otp_model.sv
/*
 Behavioural one-time-programmable array that answers the reset loader.
 Assumes one-cycle read strobes, with data taken in the cycle after the strobe.
*/
module ola_otp_model (
    input wire logic       clk,
    input wire logic [5:0] otpAddr,
    input wire logic       otpRd,
    output logic [7:0]     otpData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] data_ff = 8'h00;
    logic       valid_ff = 1'b0;
    // identity and trim bytes.
    // Every byte holds its own address with bit 7 set, so each image shows where it came from.
    always_ff @(posedge clk) begin
        valid_ff <= otpRd;
        if (otpRd) begin
            data_ff <= 8'h80 | {2'h0, otpAddr};
        end
    end
    // Outside the data cycle the bus shows the inverse, so a late or early capture is caught.
    assign otpData = valid_ff ? data_ff : ~data_ff;
endmodule

// file: ola_pkg.sv
/*
 Constants, register map and types for the OTP reset loader and ADC limit block.
 Assumes a 40 MHz clock, an APB bus with byte addresses and an OTP with one-cycle read latency.
*/
// Functional notes
// - Single cell: threshold 800mV plus code times 32.42mV.
// - Battery mode: threshold 1699mV plus code times 47.66mV.
// - Temperature limit 115C plus 5.55C per code.
// - Reset load replaces control register defaults.
// - Load OTP 0x00, 0x01, 0x03 first.
// - Load output voltage bytes 0x09, 0x0B-0x0D.
// - Load bias and buck-boost bytes 0x0E-0x12.
// - Load linear regulator bytes 0x13-0x15.
// - Load buck bytes 0x16 through 0x19.
// - Load ADC control 0x1C and limits 0x1D.
// - Unique identifier from OTP 0x20 and 0x21.
// - Temperature grade code held from 0x2F.
// - Charge counter calibrations from 0x33, 0x34.
// - Oscillator trim constant from OTP 0x35.
// - Interrupt output low while condition pending.
// - Zero interval freezes both ADC fault flags.
package ola_pkg;

    localparam int ADDR_W     = 12;
    localparam int NUM_CTRL   = 21;
    localparam int NUM_INFO   = 8;
    localparam int NUM_LOAD   = NUM_CTRL + NUM_INFO;
    localparam int IDX_ADCCC  = 19;
    localparam int IDX_LIMITS = 20;
    localparam int INFO_OSC   = 7;

    // Printed offsets are register indices; byte address is four times the index.
    localparam logic [ADDR_W-1:0] LIMITS_INDEX = 12'h05d;
    localparam logic [ADDR_W-1:0] ADCCC_INDEX  = 12'h05c;
    localparam logic [ADDR_W-1:0] ADDR_LIMITS  = 12'(LIMITS_INDEX << 2);
    localparam logic [ADDR_W-1:0] ADDR_ADCCC   = 12'(ADCCC_INDEX << 2);
    localparam logic [ADDR_W-1:0] CTRL_END     = 12'h04c;
    localparam logic [ADDR_W-1:0] INFO_BASE    = 12'h100;
    localparam logic [ADDR_W-1:0] INFO_END     = 12'h120;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 12'h180;
    localparam logic [ADDR_W-1:0] ADDR_MASK    = 12'h184;

    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] LIMITS_RESET = 8'h00;
    localparam logic [7:0] INFO_RESET   = 8'h00;
    localparam logic [2:0] MASK_RESET   = 3'h0;

    localparam int SLT_MSB = 7;
    localparam int SLT_LSB = 3;
    localparam int OTL_MSB = 2;
    localparam int OTL_LSB = 0;
    localparam int IVL_MSB = 2;
    localparam int IVL_LSB = 0;
    localparam int ST_SUPPLY_LOW = 0;
    localparam int ST_OVERTEMP   = 1;
    localparam int ST_LOAD_DONE  = 2;

    // Supply thresholds in units of 10 uV, temperature in units of 0.01 C.
    localparam logic [18:0] SC_BASE   = 19'h138_80;
    localparam logic [18:0] SC_STEP   = 19'h00c_aa;
    localparam logic [18:0] MB_BASE   = 19'h297_ac;
    localparam logic [18:0] MB_STEP   = 19'h012_9e;
    localparam logic [15:0] TEMP_BASE = 16'h2cec;
    localparam logic [15:0] TEMP_STEP = 16'h022b;

    // OTP address of each loaded byte: 21 control images, then the 8 info bytes.
    localparam logic [5:0] OTP_MAP [NUM_LOAD] = '{
        6'h00, 6'h01, 6'h03,
        6'h09, 6'h0b, 6'h0c, 6'h0d,
        6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12,
        6'h13, 6'h14, 6'h15,
        6'h16, 6'h17, 6'h18, 6'h19,
        6'h1c, 6'h1d,
        6'h20, 6'h21, 6'h2f, 6'h30, 6'h31, 6'h33, 6'h34, 6'h35};

    typedef enum logic [1:0] {
        LD_REQ  = 2'b00,
        LD_WAIT = 2'b01,
        LD_CAP  = 2'b10,
        LD_DONE = 2'b11
    } ola_ld_state_t;

endpackage

// file: ola_top.sv
/*
 OTP reset loader, ADC limit comparison, status, interrupt and APB register file.
 Assumes APB3 signalling, synchronous inputs and ADC samples as one-cycle strobes.
*/
module ola_top #(
    parameter int SUPPLY_W = 19
) (
    input wire logic                                   clk,
    input wire logic                                   rst_b,
    input wire logic                                   psel,
    input wire logic                                   penable,
    input wire logic                                   pwrite,
    input wire logic [ola_pkg::ADDR_W-1:0]             paddr,
    input wire logic [31:0]                            pwdata,
    output logic                                       pready,
    output logic [31:0]                                prdata,
    output logic                                       pslverr,
    output logic [5:0]                                 otpAddr,
    output logic                                       otpRd,
    input wire logic [7:0]                             otpData,
    input wire logic                                   singleCellSelect,
    input wire logic                                   adcSample,
    input wire logic [SUPPLY_W-1:0]                    supplyLevel,
    input wire logic [15:0]                            tempLevel,
    output logic [ola_pkg::NUM_CTRL-1:0][7:0]          ctrlRegs_ff,
    output logic [7:0]                                 oscillatorTrim,
    output logic                                       loadDone,
    output logic                                       regulatorEnable,
    output logic                                       interruptOutLow_b
);
    if (SUPPLY_W < 19) begin : g_bad_width
        $error("SUPPLY_W must hold 19 bits of threshold");
    end

    ola_load_if ld ();

    ola_otp_loader u_loader (
        .clk   (clk),
        .rst_b (rst_b),
        .ld    (ld.loader)
    );

    assign otpAddr    = ld.otpAddr;
    assign otpRd      = ld.otpRd;
    assign ld.otpData = otpData;
    assign loadDone   = ld.done;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Address decode.

    logic [4:0] busIdx;
    logic       ctrlHit;
    logic       infoHit;
    logic       statusHit;
    logic       maskHit;
    logic       anyHit;
    wire        aligned = (paddr[1:0] == 2'b00);

    always_comb begin
        busIdx    = 5'h00;
        ctrlHit   = 1'b0;
        infoHit   = 1'b0;
        statusHit = 1'b0;
        maskHit   = 1'b0;
        if (paddr == ola_pkg::ADDR_LIMITS) begin
            ctrlHit = 1'b1;
            busIdx  = 5'(ola_pkg::IDX_LIMITS);
        end else if (paddr == ola_pkg::ADDR_ADCCC) begin
            ctrlHit = 1'b1;
            busIdx  = 5'(ola_pkg::IDX_ADCCC);
        end else if (paddr < ola_pkg::CTRL_END && aligned) begin
            ctrlHit = 1'b1;
            busIdx  = paddr[6:2];
        end else if (paddr >= ola_pkg::INFO_BASE && paddr < ola_pkg::INFO_END && aligned) begin
            infoHit = 1'b1;
            busIdx  = {2'b00, paddr[4:2]};
        end else if (paddr == ola_pkg::ADDR_STATUS) begin
            statusHit = 1'b1;
        end else if (paddr == ola_pkg::ADDR_MASK) begin
            maskHit = 1'b1;
        end
    end

    assign anyHit = ctrlHit | infoHit | statusHit | maskHit;

    ////////////////////////////////////////////////////////////////////////////////////////
    // APB slave. One wait state; the access phase stalls until the load is done.

    logic [7:0]              info_ff [ola_pkg::NUM_INFO];
    logic [2:0]              status_ff;
    logic [2:0]              mask_ff;
    logic [7:0]              rdByte;
    wire                     accessPh = psel & penable;
    wire                     answer   = accessPh & ld.done & !pready;
    wire                     busDone  = accessPh & pready;
    wire                     busWr    = busDone & pwrite & anyHit;

    assign rdByte = ctrlHit   ? ctrlRegs_ff[busIdx] :
                    infoHit   ? info_ff[busIdx[2:0]] :
                    statusHit ? {5'h00, status_ff} :
                    maskHit   ? {5'h00, mask_ff} : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= answer;
            pslverr <= answer & !anyHit;
            if (answer) begin
                prdata <= {24'h00_0000, rdByte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Control and info registers. Loader writes come first and the bus is locked out
    // until they finish, so the two never collide.

    wire loadCtrl = ld.wrEn && ld.wrIdx < 5'(ola_pkg::NUM_CTRL);
    wire loadInfo = ld.wrEn && ld.wrIdx >= 5'(ola_pkg::NUM_CTRL);
    wire [4:0] infoSlot = ld.wrIdx - 5'(ola_pkg::NUM_CTRL);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrlRegs_ff <= {ola_pkg::NUM_CTRL{ola_pkg::CTRL_RESET}};
            ctrlRegs_ff[ola_pkg::IDX_LIMITS] <= ola_pkg::LIMITS_RESET;
        end else if (loadCtrl) begin
            ctrlRegs_ff[ld.wrIdx] <= ld.wrData;
        end else if (busWr && ctrlHit) begin
            ctrlRegs_ff[busIdx] <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            info_ff <= '{default: ola_pkg::INFO_RESET};
        end else if (loadInfo) begin
            info_ff[infoSlot[2:0]] <= ld.wrData;
        end
    end

    assign oscillatorTrim = info_ff[ola_pkg::INFO_OSC];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            regulatorEnable <= 1'b0;
        end else begin
            regulatorEnable <= ld.done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Limit comparison.

    wire [7:0] limits   = ctrlRegs_ff[ola_pkg::IDX_LIMITS];
    wire [4:0] slCode   = limits[ola_pkg::SLT_MSB:ola_pkg::SLT_LSB];
    wire [2:0] otCode   = limits[ola_pkg::OTL_MSB:ola_pkg::OTL_LSB];
    wire       interval = |ctrlRegs_ff[ola_pkg::IDX_ADCCC][ola_pkg::IVL_MSB:ola_pkg::IVL_LSB];

    wire [18:0] scThresh = 19'(ola_pkg::SC_BASE + 19'(slCode) * ola_pkg::SC_STEP);
    wire [18:0] mbThresh = 19'(ola_pkg::MB_BASE + 19'(slCode) * ola_pkg::MB_STEP);
    wire [18:0] supplyThresh = singleCellSelect ? scThresh : mbThresh;
    wire [15:0] tempLimit = 16'(ola_pkg::TEMP_BASE + 16'(otCode) * ola_pkg::TEMP_STEP);

    wire supplyLow = supplyLevel < SUPPLY_W'(supplyThresh);
    wire overTemp  = tempLevel > tempLimit;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Status, mask and interrupt. A set in the same cycle as a clear wins.

    logic [2:0] statusSet;
    logic [2:0] statusClr;
    logic [2:0] nxt_status;

    assign statusSet[ola_pkg::ST_SUPPLY_LOW] = adcSample & interval & supplyLow;
    assign statusSet[ola_pkg::ST_OVERTEMP]   = adcSample & interval & overTemp;
    assign statusSet[ola_pkg::ST_LOAD_DONE]  = ld.done & !regulatorEnable;
    assign statusClr  = (busWr && statusHit) ? pwdata[2:0] : 3'h0;
    assign nxt_status = (status_ff & ~statusClr) | statusSet;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status_ff <= 3'h0;
            mask_ff   <= ola_pkg::MASK_RESET;
        end else begin
            status_ff <= nxt_status;
            if (busWr && maskHit) begin
                mask_ff <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            interruptOutLow_b <= 1'b1;
        end else begin
            interruptOutLow_b <= ~|(status_ff & mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_ready_after_load: assert property (!ld.done |-> !pready && !regulatorEnable)
        else $error("bus answered or regulators enabled before load finished");
    a_irq_level: assert property (##1 interruptOutLow_b == !$past(|(status_ff & mask_ff)))
        else $error("interrupt output does not follow masked status");
    a_supply_cause: assert property ($rose(status_ff[0]) |-> $past(adcSample && interval))
        else $error("supply flag set without an enabled sample");
    a_flags_frozen: assert property (!interval && !(busWr && statusHit) |=>
        status_ff[1:0] == $past(status_ff[1:0]))
        else $error("ADC flags changed with zero interval");
    a_sc_threshold: assert property (adcSample && interval && singleCellSelect
        && supplyLevel < SUPPLY_W'(19'h13880 + 19'(slCode) * 19'h0caa) |=> status_ff[0])
        else $error("single cell low supply not flagged");
    a_mb_threshold: assert property (adcSample && interval && !singleCellSelect
        && supplyLevel < SUPPLY_W'(19'h297ac + 19'(slCode) * 19'h129e) |=> status_ff[0])
        else $error("battery low supply not flagged");
    a_temp_limit: assert property (adcSample && interval
        && tempLevel > 16'(16'h2cec + 16'(otCode) * 16'h022b) |=> status_ff[1])
        else $error("over temperature not flagged");
    a_load_lands: assert property (loadCtrl |=> ctrlRegs_ff[$past(ld.wrIdx)] == $past(ld.wrData))
        else $error("OTP byte did not land in its register");
    a_set_wins: assert property (statusSet[0] && statusClr[0] |=> status_ff[0])
        else $error("clear beat a simultaneous set");

    c_bus_write: cover property (busWr && ctrlHit && busIdx == 5'(ola_pkg::IDX_LIMITS));
    c_irq_fire: cover property ($fell(interruptOutLow_b));
    c_unmapped: cover property (pready && pslverr);
endmodule

// file: testbench.sv
/*
 Self-checking bench for the OTP reset loader and ADC limit block.
 Assumes the OTP model stores 0x80 plus the address in every byte.
*/
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [11:0]           paddr = 12'h000;
    logic [31:0]           pwdata = 32'h0;
    logic                  singleCell = 1'b0;
    logic                  adcSample = 1'b0;
    logic [18:0]           supplyLevel = 19'h0;
    logic [15:0]           tempLevel = 16'h0;
    logic [31:0]           prdata;
    logic [20:0][7:0]      ctrlRegs;
    logic [7:0]            oscTrim;
    logic [7:0]            otpData;
    logic [5:0]            otpAddr;
    logic                  pready, pslverr, otpRd, loadDone, regEn, irqLow_b;
    int                    mismatches = 0;
    int                    n_checks = 0;

    always #12.5 clk = ~clk;

    ola_top dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .otpAddr(otpAddr), .otpRd(otpRd), .otpData(otpData), .singleCellSelect(singleCell),
        .adcSample(adcSample), .supplyLevel(supplyLevel), .tempLevel(tempLevel),
        .ctrlRegs_ff(ctrlRegs), .oscillatorTrim(oscTrim), .loadDone(loadDone),
        .regulatorEnable(regEn), .interruptOutLow_b(irqLow_b));
    ola_otp_model otp (.clk(clk), .otpAddr(otpAddr), .otpRd(otpRd), .otpData(otpData));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The request stands until pready is sampled high at a rising edge; it is released there.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 400);
        if (n >= 400) begin
            mismatches++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic sample(input logic sc, input int s, input int t);
        @(posedge clk);
        singleCell <= sc;
        adcSample <= 1'b1;
        supplyLevel <= 19'(s);
        tempLevel <= 16'(t);
        @(posedge clk);
        adcSample <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_load();
        logic [31:0] d;
        logic        e;
        chk("limits in reset", ctrlRegs[20], ola_pkg::LIMITS_RESET);
        chk("regulator in reset", regEn, 1'b0);
        chk("irq in reset", irqLow_b, 1'b1);
        rst_b <= 1'b1;
        apb(1'b0, ola_pkg::ADDR_LIMITS, 32'h0, d, e);
        chk("load before answer", loadDone, 1'b1);
        chk("regulator after load", regEn, 1'b1);
        chk("limits loaded", d, 32'h9d);
        for (int i = 0; i < ola_pkg::NUM_CTRL; i++) begin
            chk("ctrl image", ctrlRegs[i], 8'h80 | {2'h0, ola_pkg::OTP_MAP[i]});
        end
        chk("osc trim", oscTrim, 8'hb5);
        $display("test load finished");
    endtask

    task automatic t_info();
        logic [31:0] d;
        logic        e;
        for (int i = 0; i < ola_pkg::NUM_INFO; i++) begin
            apb(1'b0, ola_pkg::INFO_BASE + 12'(4 * i), 32'h0, d, e);
            chk("info byte", d, 8'h80 | {2'h0, ola_pkg::OTP_MAP[21 + i]});
        end
        apb(1'b1, ola_pkg::INFO_BASE, 32'hff, d, e);
        apb(1'b0, ola_pkg::INFO_BASE, 32'h0, d, e);
        chk("id kept", d, 32'ha0);
        chk("id no error", e, 1'b0);
        apb(1'b0, 12'h200, 32'h0, d, e);
        chk("unmapped error", e, 1'b1);
        chk("unmapped data", d, 32'h0);
        $display("test info finished");
    endtask

    // Each mode is tried exactly at its threshold and one step beyond it.
    task automatic t_adc();
        logic [31:0] d;
        logic        e;
        int          code;
        int          tl;
        int          thr;
        int          lim;
        apb(1'b1, ola_pkg::ADDR_MASK, 32'h3, d, e);
        for (int sc = 0; sc < 2; sc++) begin
            code = sc ? 31 : 5;
            tl = sc ? 7 : 2;
            thr = sc ? 80000 + code * 3242 : 169900 + code * 4766;
            lim = 11500 + 555 * tl;
            apb(1'b1, ola_pkg::ADDR_LIMITS, 32'((code << 3) | tl), d, e);
            sample(sc[0], thr, lim);
            apb(1'b0, ola_pkg::ADDR_STATUS, 32'h0, d, e);
            chk("flags at limit", d & 32'h3, 32'h0);
            chk("irq quiet", irqLow_b, 1'b1);
            sample(sc[0], thr - 1, lim + 1);
            apb(1'b0, ola_pkg::ADDR_STATUS, 32'h0, d, e);
            chk("flags past limit", d & 32'h3, 32'h3);
            chk("irq pending", irqLow_b, 1'b0);
            apb(1'b1, ola_pkg::ADDR_STATUS, 32'h3, d, e);
            apb(1'b0, ola_pkg::ADDR_STATUS, 32'h0, d, e);
            chk("flags cleared", d & 32'h3, 32'h0);
            chk("irq released", irqLow_b, 1'b1);
        end
        // The sample is timed to land on the edge at which the clear is written.
        fork
            apb(1'b1, ola_pkg::ADDR_STATUS, 32'h1, d, e);
            begin
                repeat (2) @(posedge clk);
                sample(1'b1, thr - 1, lim);
            end
        join
        apb(1'b0, ola_pkg::ADDR_STATUS, 32'h0, d, e);
        chk("set beats clear", d & 32'h3, 32'h1);
        apb(1'b1, ola_pkg::ADDR_STATUS, 32'h1, d, e);
        apb(1'b1, ola_pkg::ADDR_ADCCC, 32'h0, d, e);
        sample(1'b0, 0, 40000);
        apb(1'b0, ola_pkg::ADDR_STATUS, 32'h0, d, e);
        chk("frozen flags", d & 32'h3, 32'h0);
        $display("test adc finished");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        t_load();
        t_info();
        t_adc();
        close_out();
    end

    // The tests need well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule
